// *** pkg/i2cmbs_pkg.sv ***
/*
  Shared constants and types for the two-wire master timing core: control
  bit positions, flag indices, reset values, sequencer states and the
  packed state records of each module.
  Assumes a 200 MHz system clock and a separate link sampling clock.
*/
package i2cmbs_pkg;

  // ************************************************************
  // control and flag layout
  // ************************************************************
  localparam int CTRL_WIDTH = 5;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_RSTART_BIT = 1;
  localparam int CTRL_HI_LSB = 2;
  localparam int STATUS_START_BIT = 3;
  localparam int FLAG_WIDTH = 4;
  localparam int FLAG_START = 0;
  localparam int FLAG_BUSCOL = 1;
  localparam int FLAG_WRITE_COLLISION_FLAG = 2;
  localparam int FLAG_IRQ = 3;
  localparam int RELOAD_WIDTH = 7;
  localparam int RSTART_RELOAD_WIDTH = 6;
  localparam int BUF_WIDTH = 8;

  // ************************************************************
  // sequencer states
  // ************************************************************
  typedef enum logic [3:0] {
    SQ_IDLE = 4'h0,
    SQ_S_ARM = 4'h1,
    SQ_S_WAIT = 4'h2,
    SQ_S_HOLD = 4'h3,
    SQ_R_SCLLOW = 4'h4,
    SQ_R_SDAHI = 4'h5,
    SQ_R_SCLREL = 4'h6,
    SQ_R_BOTHHI = 4'h7,
    SQ_R_SDALOW = 4'h8
  } i2cmbs_state_t;

  typedef struct packed {
    i2cmbs_state_t state;
    logic sclMeta;
    logic sclLvl;
    logic sdaMeta;
    logic sdaLvl;
    logic sclOe;
    logic sdaOe;
    logic pinLow;
    logic startEn;
    logic rstartEn;
    logic [2:0] ctrlHi;
    logic startSeen;
    logic busCol;
    logic write_collision_flag;
    logic irq;
    logic [BUF_WIDTH-1:0] shiftBuf;
    logic load;
    logic [RELOAD_WIDTH-1:0] loadVal;
    logic busy;
  } i2cmbs_chan_t;

  localparam i2cmbs_chan_t CHAN_RESET = '{
    state: SQ_IDLE, sclMeta: 1'b1, sclLvl: 1'b1, sdaMeta: 1'b1,
    sdaLvl: 1'b1, default: '0};

  typedef struct packed {
    logic [RELOAD_WIDTH-1:0] cnt;
    logic run;
    logic phase;
    logic tmo;
  } i2cmbs_baud_t;

  localparam i2cmbs_baud_t BAUD_RESET = '0;

  // bit 1 is clock, bit 0 is data; idle bus reads high
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] lvl;
  } i2cmbs_samp_t;

  localparam i2cmbs_samp_t SAMP_RESET = '{default: 2'h3};

endpackage

// *** verilog/i2cmbs_line_sampler.sv ***
/*
  Samples the clock and data pins of one port on the link clock.
  Assumes the pins are asynchronous; the filtered levels are crossed
  into the system clock domain by the caller.
*/
`timescale 1ns/10ps
`default_nettype none
module i2cmbs_line_sampler
  import i2cmbs_pkg::*;
(
  input wire logic linkClk,
  input wire logic resetn,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sclLvl,
  output logic sdaLvl
);

  i2cmbs_samp_t r;
  i2cmbs_samp_t n;

  always_comb
  begin
    n = r;
    n.s1 = {sclIn, sdaIn};
    n.s2 = r.s1;
    n.s3 = r.s2;
    // a change counts only once the second and third stage agree
    for (int b = 0; b < 2; b++)
    begin
      if (r.s2[b] == r.s3[b])
      begin
        n.lvl[b] = r.s3[b];
      end
    end
  end

  always_ff @(posedge linkClk or negedge resetn)
  begin
    if (!resetn)
    begin
      r <= SAMP_RESET;
    end
    else
    begin
      r <= n;
    end
  end

  assign sclLvl = r.lvl[1];
  assign sdaLvl = r.lvl[0];

endmodule
`default_nettype wire

// *** verilog/i2cmbs_baud_counter.sv ***
/*
  Baud rate down-counter of one port: loads the reload value, steps
  down every second system clock and stops at zero with a timeout pulse.
  Assumes the caller never loads zero.
*/
`timescale 1ns/10ps
`default_nettype none
module i2cmbs_baud_counter
  import i2cmbs_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [RELOAD_WIDTH-1:0] reloadValue,
  output logic timeout,
  output logic running
);

  i2cmbs_baud_t r;
  i2cmbs_baud_t n;

  always_comb
  begin
    n = r;
    n.tmo = 1'b0;
    n.phase = ~r.phase;
    if (load)
    begin
      n.cnt = reloadValue;
      n.run = 1'b1;
      n.phase = 1'b0;
    end
    else if (r.run && r.phase)
    begin
      // two steps per instruction cycle; halts at zero until reloaded
      if (r.cnt == '0)
      begin
        n.run = 1'b0;
        n.tmo = 1'b1;
      end
      else
      begin
        n.cnt = r.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      r <= BAUD_RESET;
    end
    else
    begin
      r <= n;
    end
  end

  assign timeout = r.tmo;
  assign running = r.run;

endmodule
`default_nettype wire

// *** verilog/i2cmbs_top.sv ***
/*
  Master timing core of the two-wire serial ports: per port a baud
  generator, clock arbitration, Start and Repeated Start sequencing,
  bus collision and write collision detection.
  Assumes open-drain pins resolved outside, pins sampled on linkClk,
  and byte, acknowledge and Stop engines living elsewhere.
*/
`timescale 1ns/10ps
`default_nettype none
module i2cmbs_top
  import i2cmbs_pkg::*;
#(
  parameter int NPORT = 2
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic linkClk,
  input wire logic [NPORT-1:0] sclIn,
  input wire logic [NPORT-1:0] sdaIn,
  output logic [NPORT-1:0] sclOut,
  output logic [NPORT-1:0] sclOe,
  output logic [NPORT-1:0] sdaOut,
  output logic [NPORT-1:0] sdaOe,
  input wire logic [NPORT-1:0][RELOAD_WIDTH-1:0] reloadValue,
  input wire logic [NPORT-1:0] ctrlWrite,
  input wire logic [NPORT-1:0][CTRL_WIDTH-1:0] ctrlWdata,
  input wire logic [NPORT-1:0] bufWrite,
  input wire logic [NPORT-1:0][BUF_WIDTH-1:0] bufWdata,
  input wire logic [NPORT-1:0][FLAG_WIDTH-1:0] flagClear,
  output logic [NPORT-1:0][CTRL_WIDTH-1:0] ctrlBits,
  output logic [NPORT-1:0] startSeen,
  output logic [NPORT-1:0] busCollision,
  output logic [NPORT-1:0] writeCollision,
  output logic [NPORT-1:0] portIrq,
  output logic [NPORT-1:0][BUF_WIDTH-1:0] shiftBuffer,
  output logic [NPORT-1:0] seqBusy,
  output logic [NPORT-1:0] genTimeout
);

  // ************************************************************
  // one complete engine per port
  // ************************************************************
  // every port has its own generator, reload input and sequencer
  for (genvar i = 0; i < NPORT; i++)
  begin : g_port
    i2cmbs_chan_t r;
    i2cmbs_chan_t n;
    logic sclLink;
    logic sdaLink;
    logic tmo;

    // ************************************************************
    // pin sampling
    // ************************************************************
    // filtered on the link clock, then two system flops below; the
    // extra latency only stretches arbitration by a few cycles
    i2cmbs_line_sampler u_samp (
      .linkClk(linkClk),
      .resetn(resetn),
      .sclIn(sclIn[i]),
      .sdaIn(sdaIn[i]),
      .sclLvl(sclLink),
      .sdaLvl(sdaLink)
    );

    // ************************************************************
    // baud generator
    // ************************************************************
    // one rollover is (reload + 1) steps; a clock period is two
    i2cmbs_baud_counter u_baud (
      .clk(clk),
      .resetn(resetn),
      .load(r.load),
      .reloadValue(r.loadVal),
      .timeout(tmo),
      .running()
    );

    // ************************************************************
    // sequencer
    // ************************************************************
    always_comb
    begin
      logic scl;
      logic sda;
      logic collide;
      // steps below only see the crossed, registered line levels
      scl = r.sclLvl;
      sda = r.sdaLvl;
      collide = 1'b0;
      n = r;
      n.load = 1'b0;
      // two-flop crossing of the filtered link-domain levels
      n.sclMeta = sclLink;
      n.sclLvl = r.sclMeta;
      n.sdaMeta = sdaLink;
      n.sdaLvl = r.sdaMeta;

      // ************************************************************
      // flags
      // ************************************************************
      // clears first so a same-cycle event below still sets its flag
      if (flagClear[i][FLAG_START])
      begin
        n.startSeen = 1'b0;
      end
      if (flagClear[i][FLAG_BUSCOL])
      begin
        n.busCol = 1'b0;
      end
      if (flagClear[i][FLAG_WRITE_COLLISION_FLAG])
      begin
        n.write_collision_flag = 1'b0;
      end
      if (flagClear[i][FLAG_IRQ])
      begin
        n.irq = 1'b0;
      end

      // ************************************************************
      // buffer port
      // ************************************************************
      // no queueing: a buffer write during a sequence is dropped
      if (bufWrite[i])
      begin
        if (r.state != SQ_IDLE)
        begin
          n.write_collision_flag = 1'b1;
        end
        else
        begin
          n.shiftBuf = bufWdata[i];
        end
      end

      // ************************************************************
      // start and repeated start steps
      // ************************************************************
      case (r.state)
        SQ_IDLE:
        begin
          // control writes are only taken here, so nothing queues
          if (ctrlWrite[i])
          begin
            n.ctrlHi = ctrlWdata[i][CTRL_WIDTH-1:CTRL_HI_LSB];
            if (ctrlWdata[i][CTRL_START_BIT])
            begin
              n.startEn = 1'b1;
              n.state = SQ_S_ARM;
            end
            // start wins when both enables arrive together
            else if (ctrlWdata[i][CTRL_RSTART_BIT])
            begin
              n.rstartEn = 1'b1;
              n.sclOe = 1'b1;
              n.state = SQ_R_SCLLOW;
            end
          end
        end
        SQ_S_ARM:
        begin
          if (!scl && !sda)
          begin
            collide = 1'b1;
          end
          // mixed levels: someone is mid-transfer, keep waiting
          else if (scl && sda)
          begin
            n.load = 1'b1;
            n.loadVal = reloadValue[i];
            n.state = SQ_S_WAIT;
          end
        end
        SQ_S_WAIT:
        begin
          if (!scl)
          begin
            collide = 1'b1;
          end
          else if (tmo)
          begin
            if (sda)
            begin
              n.sdaOe = 1'b1;
              n.startSeen = 1'b1;
              n.load = 1'b1;
              n.loadVal = reloadValue[i];
              n.state = SQ_S_HOLD;
            end
            else
            begin
              // data pulled low by someone else before our start
              collide = 1'b1;
            end
          end
        end
        SQ_S_HOLD:
        begin
          if (tmo)
          begin
            // generator left stopped, data stays driven low
            n.startEn = 1'b0;
            n.irq = 1'b1;
            n.state = SQ_IDLE;
          end
        end
        SQ_R_SCLLOW:
        begin
          if (!scl)
          begin
            n.sdaOe = 1'b0;
            n.load = 1'b1;
            // first rollover uses the six-bit reload, bit 6 forced low
            n.loadVal = {1'b0, reloadValue[i][RSTART_RELOAD_WIDTH-1:0]};
            n.state = SQ_R_SDAHI;
          end
        end
        SQ_R_SDAHI:
        begin
          if (tmo)
          begin
            if (sda)
            begin
              n.sclOe = 1'b0;
              n.state = SQ_R_SCLREL;
            end
            else
            begin
              // data still low at timeout: another party holds it
              collide = 1'b1;
            end
          end
        end
        SQ_R_SCLREL:
        begin
          // generator idles while the clock is held low elsewhere
          if (scl)
          begin
            if (!sda)
            begin
              collide = 1'b1;
            end
            else
            begin
              n.load = 1'b1;
              n.loadVal = reloadValue[i];
              n.state = SQ_R_BOTHHI;
            end
          end
        end
        SQ_R_BOTHHI:
        begin
          // either line low here means another master owns the bus
          if (!scl || !sda)
          begin
            collide = 1'b1;
          end
          else if (tmo)
          begin
            n.sdaOe = 1'b1;
            n.load = 1'b1;
            n.loadVal = reloadValue[i];
            n.state = SQ_R_SDALOW;
          end
        end
        SQ_R_SDALOW:
        begin
          // start flag follows the lines, not our own drive
          if (scl && !sda)
          begin
            n.startSeen = 1'b1;
          end
          if (tmo)
          begin
            // no reload here; data remains low for the next engine
            n.rstartEn = 1'b0;
            n.irq = 1'b1;
            n.state = SQ_IDLE;
          end
        end
        default:
        begin
          // an unknown code drops the bus rather than hold it
          n.sclOe = 1'b0;
          n.sdaOe = 1'b0;
          n.startEn = 1'b0;
          n.rstartEn = 1'b0;
          n.state = SQ_IDLE;
        end
      endcase

      // ************************************************************
      // collision
      // ************************************************************
      // a collision gives the bus back and returns to idle
      if (collide)
      begin
        n.busCol = 1'b1;
        n.startEn = 1'b0;
        n.rstartEn = 1'b0;
        n.sclOe = 1'b0;
        n.sdaOe = 1'b0;
        n.load = 1'b0;
        n.state = SQ_IDLE;
      end

      // busy is kept as its own flop so the port needs no decode
      n.busy = (n.state != SQ_IDLE);
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clk or negedge resetn)
    begin
      if (!resetn)
      begin
        r <= CHAN_RESET;
      end
      else
      begin
        r <= n;
      end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // open drain: drive value stays low, the enable does the work
    assign sclOut[i] = r.pinLow;
    assign sdaOut[i] = r.pinLow;
    assign sclOe[i] = r.sclOe;
    assign sdaOe[i] = r.sdaOe;
    assign ctrlBits[i] = {r.ctrlHi, r.rstartEn, r.startEn};
    assign startSeen[i] = r.startSeen;
    assign busCollision[i] = r.busCol;
    assign writeCollision[i] = r.write_collision_flag;
    assign portIrq[i] = r.irq;
    assign shiftBuffer[i] = r.shiftBuf;
    assign seqBusy[i] = r.busy;
    assign genTimeout[i] = tmo;
  end

endmodule
`default_nettype wire

// *** tb/i2cmbs_top_monitor.sv ***
/*
  Concurrent checks on the ports of the two-wire master timing core.
  Assumes it is bound into i2cmbs_top with NPORT of at least 2.
*/
`timescale 1ns/10ps
`default_nettype none
module i2cmbs_top_monitor
  import i2cmbs_pkg::*;
#(
  parameter int NPORT = 2
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [NPORT-1:0] sclOut,
  input wire logic [NPORT-1:0] sclOe,
  input wire logic [NPORT-1:0] sdaOut,
  input wire logic [NPORT-1:0] sdaOe,
  input wire logic [NPORT-1:0][RELOAD_WIDTH-1:0] reloadValue,
  input wire logic [NPORT-1:0] ctrlWrite,
  input wire logic [NPORT-1:0][CTRL_WIDTH-1:0] ctrlWdata,
  input wire logic [NPORT-1:0] bufWrite,
  input wire logic [NPORT-1:0][CTRL_WIDTH-1:0] ctrlBits,
  input wire logic [NPORT-1:0] busCollision,
  input wire logic [NPORT-1:0] writeCollision,
  input wire logic [NPORT-1:0] portIrq,
  input wire logic [NPORT-1:0][BUF_WIDTH-1:0] shiftBuffer,
  input wire logic [NPORT-1:0] seqBusy,
  input wire logic [NPORT-1:0] genTimeout
);
  // ************************************************************
  // helper: cycles since the last generator timeout, saturating
  // ************************************************************
  logic [1:0][8:0] gap_r;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gap_r <= '0;
    end
    else
    begin
      for (int p = 0; p < 2; p++)
      begin
        if (genTimeout[p])
          gap_r[p] <= '0;
        else if (gap_r[p] != 9'h1ff)
          gap_r[p] <= gap_r[p] + 9'h001;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_startReq;
    !seqBusy[0] && ctrlWrite[0] && ctrlWdata[0][0];
  endsequence
  sequence s_busyBuf;
    seqBusy[0] && bufWrite[0];
  endsequence
  open_drain_a: assert property (sclOut == '0 && sdaOut == '0)
    else $error("pin drive value not zero");
  start_accept_a: assert property (s_startReq |=> seqBusy[0] && ctrlBits[0][0])
    else $error("start request not taken");
  ctrl_lock_a: assert property (seqBusy[0] && ctrlWrite[0] |=> $stable(ctrlBits[0][4:2]))
    else $error("control write taken while busy");
  buf_refuse_a: assert property (s_busyBuf |=> writeCollision[0] && $stable(shiftBuffer[0]))
    else $error("busy buffer write not refused");
  col_release_a: assert property ($rose(busCollision[0]) |-> !sclOe[0] && !sdaOe[0] && !seqBusy[0])
    else $error("collision left lines driven");
  sda_keep_a: assert property ($fell(sdaOe[0]) |-> busCollision[0] || ctrlBits[0][1])
    else $error("data line released unexpectedly");
  irq_done_a: assert property ($rose(portIrq[0]) |-> $fell(seqBusy[0]) && ctrlBits[0][1:0] == 2'h0)
    else $error("interrupt not at sequence end");
  rstart_pull_a: assert property ($rose(ctrlBits[0][1]) |-> sclOe[0])
    else $error("repeated start without clock low");
  gap_zero_a: assert property (genTimeout[0] |-> gap_r[0] >= 2 * reloadValue[0] + 1)
    else $error("port 0 rollover too short");
  gap_one_a: assert property (genTimeout[1] |-> gap_r[1] >= 2 * reloadValue[1] + 1)
    else $error("port 1 rollover too short");
endmodule
bind i2cmbs_top i2cmbs_top_monitor #(.NPORT(NPORT)) u_mon (.clk(clk),
  .resetn(resetn), .sclOut(sclOut), .sclOe(sclOe),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .reloadValue(reloadValue),
  .ctrlWrite(ctrlWrite), .ctrlWdata(ctrlWdata), .bufWrite(bufWrite),
  .ctrlBits(ctrlBits), .busCollision(busCollision),
  .writeCollision(writeCollision), .portIrq(portIrq),
  .shiftBuffer(shiftBuffer), .seqBusy(seqBusy), .genTimeout(genTimeout));
`default_nettype wire

// *** tb/i2cmbs_bus_model.sv ***
/*
  Shared two-wire bus per port: pull-ups and other parties on the bus.
  Assumes holdScl/holdSda are commanded by the bench to stretch or clash.
*/
`timescale 1ns/10ps
`default_nettype none
module i2cmbs_bus_model
#(
  parameter int NPORT = 2
)
(
  input wire logic [NPORT-1:0] sclOe,
  input wire logic [NPORT-1:0] sdaOe,
  input wire logic [NPORT-1:0] holdScl,
  input wire logic [NPORT-1:0] holdSda,
  output logic [NPORT-1:0] sclIn,
  output logic [NPORT-1:0] sdaIn
);
  // ************************************************************
  // wired-and: any party pulling low wins over the pull-up
  // ************************************************************
  assign sclIn = ~(sclOe | holdScl);
  assign sdaIn = ~(sdaOe | holdSda);
endmodule
`default_nettype wire

// *** tb/i2cmbs_bench.sv ***
/*
  Self-checking bench for the two-wire master timing core.
  Assumes pins are resolved by i2cmbs_bus_model; link clock runs free.
*/
`timescale 1ns/10ps
`default_nettype none
module i2cmbs_bench;
  logic clk = 1'b0;
  logic linkClk = 1'b0;
  logic resetn;
  logic [1:0] sclIn, sdaIn, sclOut, sclOe, sdaOut, sdaOe, holdScl, holdSda;
  logic [1:0][6:0] reloadValue;
  logic [1:0] ctrlWrite, bufWrite, startSeen, busCollision;
  logic [1:0] writeCollision, portIrq, seqBusy, genTimeout;
  logic [1:0][4:0] ctrlWdata, ctrlBits;
  logic [1:0][7:0] bufWdata, shiftBuffer;
  logic [1:0][3:0] flagClear;
  int n_fail = 0;
  int checks_done = 0;
  int n0, n1;
  always #2.5 clk = ~clk;
  initial
  begin
    #3.7;
    forever #16 linkClk = ~linkClk;
  end
  i2cmbs_top #(.NPORT(2)) u_dut (.clk(clk), .resetn(resetn),
    .linkClk(linkClk), .sclIn(sclIn), .sdaIn(sdaIn), .sclOut(sclOut),
    .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .reloadValue(reloadValue), .ctrlWrite(ctrlWrite),
    .ctrlWdata(ctrlWdata), .bufWrite(bufWrite), .bufWdata(bufWdata),
    .flagClear(flagClear), .ctrlBits(ctrlBits), .startSeen(startSeen),
    .busCollision(busCollision), .writeCollision(writeCollision),
    .portIrq(portIrq), .shiftBuffer(shiftBuffer), .seqBusy(seqBusy),
    .genTimeout(genTimeout));
  i2cmbs_bus_model #(.NPORT(2)) u_bus (.sclOe(sclOe), .sdaOe(sdaOe),
    .holdScl(holdScl), .holdSda(holdSda), .sclIn(sclIn), .sdaIn(sdaIn));
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic results();
    if (n_fail == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic ctrl(input logic [1:0] m, input logic [4:0] d);
    ctrlWdata = {d, d};
    ctrlWrite = m;
    step(1);
    ctrlWrite = '0;
    step(1);
  endtask
  task automatic bufw(input logic [1:0] m, input logic [7:0] d);
    bufWdata = {d, d};
    bufWrite = m;
    step(1);
    bufWrite = '0;
    step(1);
  endtask
  task automatic clr();
    flagClear = {4'hf, 4'hf};
    step(1);
    flagClear = '0;
    step(1);
  endtask
  task automatic wait_idle(input int p, output int n);
    n = 0;
    while (seqBusy[p] !== 1'b0 && n < 2000)
    begin
      step(1);
      n++;
    end
    if (n >= 2000)
    begin
      n_fail++;
      results();
    end
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_start_both();
    reloadValue = {7'h28, 7'h14};
    ctrl(2'b11, 5'h01);
    chk("busy", 16'h3, seqBusy);
    ctrl(2'b01, 5'h1e);
    bufw(2'b01, 8'h5a);
    chk("write_collision_flag", 16'h1, writeCollision[0]);
    chk("buf", 16'h0, shiftBuffer[0]);
    wait_idle(0, n0);
    wait_idle(1, n1);
    chk("rate0", 16'h1, n0 >= 78 && n0 <= 140);
    chk("rate1", 16'h1, n1 > 0 && n0 + n1 >= 158);
    chk("ctrl", 16'h0, ctrlBits[0]);
    chk("seen", 16'h3, startSeen);
    chk("irq", 16'h3, portIrq);
    chk("sdaoe", 16'h3, sdaOe);
    bufw(2'b01, 8'ha5);
    chk("buf", 16'ha5, shiftBuffer[0]);
    ctrl(2'b01, 5'h1c);
    chk("hi", 16'h1c, ctrlBits[0]);
    clr();
  endtask
  task automatic t_rstart_stretch();
    ctrl(2'b01, 5'h02);
    chk("sclpull", 16'h1, sclOe[0]);
    bufw(2'b01, 8'h3c);
    chk("write_collision_flag", 16'h1, writeCollision[0]);
    bufWrite = 2'b01;
    flagClear = {4'h0, 4'h4};
    step(1);
    bufWrite = '0;
    flagClear = '0;
    step(1);
    chk("wset", 16'h1, writeCollision[0]);
    holdScl[0] = 1'b1;
    step(250);
    chk("stretch", 16'h1, seqBusy[0] && !sclOe[0] && !portIrq[0]);
    holdScl[0] = 1'b0;
    wait_idle(0, n0);
    chk("ctrl", 16'h0, ctrlBits[0]);
    chk("sda", 16'h1, sdaOe[0] && !sclOe[0]);
    chk("seen", 16'h1, startSeen[0] && portIrq[0]);
    chk("bcol", 16'h0, busCollision[0]);
    clr();
  endtask
  task automatic t_start_abort();
    holdScl[0] = 1'b1;
    step(40);
    ctrl(2'b01, 5'h01);
    chk("bcol0", 16'h1, busCollision[0] && !sdaOe[0]);
    chk("ctrl0", 16'h0, ctrlBits[0]);
    clr();
    holdScl[0] = 1'b0;
    step(40);
    ctrl(2'b01, 5'h01);
    holdScl[0] = 1'b1;
    wait_idle(0, n0);
    chk("ecol", 16'h1, busCollision[0] && !startSeen[0]);
    chk("ecnt", 16'h1, n0 < 45);
    holdScl[0] = 1'b0;
    clr();
  endtask
  task automatic t_collide();
    holdScl[1] = 1'b1;
    step(40);
    ctrl(2'b10, 5'h01);
    wait_idle(1, n1);
    chk("bcol", 16'h1, busCollision[1] && !sdaOe[1] && !portIrq[1]);
    chk("ctrl", 16'h0, ctrlBits[1]);
    clr();
    holdScl[1] = 1'b0;
    holdSda[1] = 1'b1;
    step(40);
    ctrl(2'b10, 5'h02);
    wait_idle(1, n1);
    chk("rbcol", 16'h1, busCollision[1] && !sclOe[1]);
    holdSda[1] = 1'b0;
  endtask
  initial
  begin
    #100000;
    n_fail++;
    results();
  end
  initial
  begin
    resetn = 1'b0;
    holdScl = '0;
    holdSda = '0;
    reloadValue = {7'h28, 7'h14};
    ctrlWrite = '0;
    ctrlWdata = '0;
    bufWrite = '0;
    bufWdata = '0;
    flagClear = '0;
    repeat (16) @(posedge clk);
    #1;
    resetn = 1'b1;
    step(40);
    t_start_both();
    t_rstart_stretch();
    t_start_abort();
    t_collide();
    results();
  end
endmodule
`default_nettype wire
